// ===== shared/isr_pkg.sv
/*
 * Shared constants and types for the two-wire register access slave.
 * Assumes an 8-bit register space behind a 16-bit address pointer.
 */
package isr_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ISR_ADDR_W  = 16;      // register pointer width
	localparam int ISR_DATA_W  = 8;       // one byte per register
	localparam int ISR_SLV_W   = 7;       // slave address width
	localparam int ISR_SEL_W   = 2;       // selects one of four addresses

	// ------------------------------------------------------------
	// field positions and codes
	// ------------------------------------------------------------
	localparam logic [2:0] ISR_LAST_BIT   = 3'h7;  // eighth bit of a byte
	localparam logic       ISR_DIR_WRITE  = 1'h0;  // direction bit: master writes
	localparam int         ISR_DIR_POS    = 0;     // direction bit in address byte
	localparam logic [1:0] ISR_IDX_HI     = 2'h0;  // byte index: pointer high
	localparam logic [1:0] ISR_IDX_LO     = 2'h1;  // byte index: pointer low
	localparam logic [1:0] ISR_IDX_DATA   = 2'h2;  // byte index: payload

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [ISR_ADDR_W-1:0] ISR_PTR_RST = 16'h0000;
	// default base slave address; the value is arbitrary
	localparam logic [ISR_SLV_W-1:0]  ISR_SLV_BASE_DEF = 7'h48;

	// ------------------------------------------------------------
	// protocol engine states
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_ADDR  = 8'h02,
		ST_AACK  = 8'h04,
		ST_WRX   = 8'h08,
		ST_WACK  = 8'h10,
		ST_RLOAD = 8'h20,
		ST_RTX   = 8'h40,
		ST_RACK  = 8'h80
	} isr_state_t;

endpackage

// ===== shared/isr_line_if.sv
/*
 * Carrier for the sampled bus line levels and bus events.
 * Assumes both ends sit in the link clock domain.
 */
`timescale 1ns/10ps
interface isr_line_if;
	logic scl;       // synchronised clock line level
	logic sda;       // synchronised data line level
	logic scl_rise;  // one-cycle pulse
	logic scl_fall;  // one-cycle pulse
	logic start;     // start or repeated start seen
	logic stop;      // stop seen

	modport mon (output scl, sda, scl_rise, scl_fall, start, stop);
	modport eng (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// ===== rtl/isr_line_mon.sv
/*
 * Bus line monitor: synchronises both serial lines and derives edge,
 * start and stop events from the synchronised levels.
 * Assumes clk_i oversamples the serial clock many times per bit.
 */
`timescale 1ns/10ps
module isr_line_mon (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	isr_line_if.mon   ln
);

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic scl_m;
	logic scl_s;
	logic scl_d;
	logic sda_m;
	logic sda_s;
	logic sda_d;

	// two flops per line, then one more for edge history; lines idle high
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// events
	// ------------------------------------------------------------
	// both lines share the same sync depth, so a master hold time of a
	// few link cycles keeps data changes from reading as start or stop
	assign ln.scl      = scl_s;
	assign ln.sda      = sda_s;
	assign ln.scl_rise = scl_s & ~scl_d;
	assign ln.scl_fall = ~scl_s & scl_d;
	assign ln.start    = scl_s & scl_d & sda_d & ~sda_s;
	assign ln.stop     = scl_s & scl_d & ~sda_d & sda_s;

endmodule

// ===== rtl/isr_i2c_slave.sv
/*
 * Two-wire slave giving a bus master byte access to a 16-bit addressed
 * register space. The protocol engine runs on the link clock; register
 * accesses cross to the system clock by a toggle handshake.
 * Assumes clk_link_i runs freely and much faster than the serial clock,
 * and that reg_rdata_i is valid in the cycle after reg_rd_o.
 */
// Notes on behaviour
// - after start, a 7-bit address plus direction bit arrives, msb first
// - direction bit zero means master writes, one means master reads
// - acknowledge own address only; otherwise stay off the bus
// - any start restarts address reception from any state
// - each byte slot is eight data bits then one acknowledge bit
// - payload length is unlimited for writes and reads
// - first two written bytes load the pointer, high byte first
// - the register pointer is sixteen bits wide
// - later written bytes go to registers starting at the loaded pointer
// - reads return data starting at the current pointer
// - a pointer-only write is kept for later reads
// - pointer write, repeated start, then read is supported
// - master nonacknowledge ends a read; release data line, go idle
// - repeated start begins a new address byte
// - start or stop drops a partial byte uncommitted
// - slave only; the clock line is never driven
// - acknowledge pulls data low in the ninth pulse; high is nonacknowledge
// - data changes only with clock low; edges with clock high are start/stop
// - one of four selectable slave addresses
`timescale 1ns/10ps
module isr_i2c_slave
	import isr_pkg::*;
#(
	parameter logic [ISR_SLV_W-1:0] SLV_ADDR_BASE = ISR_SLV_BASE_DEF
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  clk_link_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_o,
	input  wire logic [ISR_SEL_W-1:0]  addr_sel_i,
	output logic [ISR_ADDR_W-1:0]      reg_addr_o,
	output logic [ISR_DATA_W-1:0]      reg_wdata_o,
	output logic                       reg_wr_o,
	output logic                       reg_rd_o,
	input  wire logic [ISR_DATA_W-1:0] reg_rdata_i
);

	// ------------------------------------------------------------
	// link domain reset and strap synchronisers
	// ------------------------------------------------------------
	logic                 rst_link_m;
	logic                 rst_link_n;
	logic [ISR_SEL_W-1:0] sel_m;
	logic [ISR_SEL_W-1:0] sel_s;
	logic [ISR_SLV_W-1:0] own_addr;

	// system reset carried into the link domain; it is the reset itself
	always_ff @(posedge clk_link_i) begin
		rst_link_m <= rst_n_i;
		rst_link_n <= rst_link_m;
	end

	// address select pins may change at any time, so they are synchronised
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			sel_m <= '0;
			sel_s <= '0;
		end else begin
			sel_m <= addr_sel_i;
			sel_s <= sel_m;
		end
	end

	// low two address bits come from the select pins
	assign own_addr = {SLV_ADDR_BASE[ISR_SLV_W-1:ISR_SEL_W], sel_s};

	// ------------------------------------------------------------
	// line monitor
	// ------------------------------------------------------------
	isr_line_if ln ();

	isr_line_mon u_mon (
		.clk_i   (clk_link_i),
		.rst_n_i (rst_link_n),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.ln      (ln)
	);

	// ------------------------------------------------------------
	// protocol engine state
	// ------------------------------------------------------------
	isr_state_t            state;
	logic [2:0]            bit_cnt;
	logic                  byte_done;
	logic [ISR_DATA_W-1:0] sh;
	logic                  rw;
	logic [1:0]            wr_idx;
	logic [ISR_DATA_W-1:0] addr_hi;
	logic [ISR_ADDR_W-1:0] ptr;
	logic [ISR_DATA_W-1:0] rbuf;
	logic                  rbuf_valid;

	// engine strobes that other processes act on
	logic addr_hit;
	logic wr_byte_ev;
	logic ptr_load;
	logic data_wr;
	logic rd_fetch;
	logic rbuf_take;

	assign addr_hit   = (state == ST_ADDR) && ln.scl_fall && byte_done
	                    && (sh[ISR_DATA_W-1:1] == own_addr);
	assign wr_byte_ev = (state == ST_WRX) && ln.scl_fall && byte_done;
	assign ptr_load   = wr_byte_ev && (wr_idx == ISR_IDX_LO);
	assign data_wr    = wr_byte_ev && (wr_idx == ISR_IDX_DATA);
	// fetch on address match for a read, or when the master acknowledges
	assign rd_fetch   = (addr_hit && (sh[ISR_DIR_POS] != ISR_DIR_WRITE))
	                    || ((state == ST_RACK) && ln.scl_rise && !ln.sda);
	assign rbuf_take  = (state == ST_RLOAD) && rbuf_valid && !ln.scl_rise
	                    && !ln.start && !ln.stop;

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	// start and stop take precedence over any byte in flight; nothing is
	// committed until the falling edge after the eighth bit
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			state     <= ST_IDLE;
			bit_cnt   <= '0;
			byte_done <= 1'b0;
			sh        <= '0;
			rw        <= 1'b0;
			wr_idx    <= ISR_IDX_HI;
			addr_hi   <= '0;
			sda_oe_o  <= 1'b0;
		end else if (ln.start) begin
			state     <= ST_ADDR;
			bit_cnt   <= '0;
			byte_done <= 1'b0;
			sda_oe_o  <= 1'b0;
		end else if (ln.stop) begin
			state     <= ST_IDLE;
			bit_cnt   <= '0;
			byte_done <= 1'b0;
			sda_oe_o  <= 1'b0;
		end else begin
			unique case (state)
			ST_IDLE: begin
				sda_oe_o <= 1'b0;
			end
			ST_ADDR, ST_WRX: begin
				if (ln.scl_rise) begin
					sh        <= {sh[ISR_DATA_W-2:0], ln.sda};
					bit_cnt   <= bit_cnt + 3'h1;
					byte_done <= (bit_cnt == ISR_LAST_BIT);
				end else if (ln.scl_fall && byte_done) begin
					byte_done <= 1'b0;
					if (state == ST_ADDR) begin
						if (addr_hit) begin
							state    <= ST_AACK;
							sda_oe_o <= 1'b1;
							rw       <= sh[ISR_DIR_POS];
							wr_idx   <= ISR_IDX_HI;
						end else begin
							state <= ST_IDLE;
						end
					end else begin
						state    <= ST_WACK;
						sda_oe_o <= 1'b1;
						if (wr_idx == ISR_IDX_HI) begin
							addr_hi <= sh;
						end
						// index stops at payload so any length is accepted
						if (wr_idx != ISR_IDX_DATA) begin
							wr_idx <= wr_idx + 2'h1;
						end
					end
				end
			end
			ST_AACK: begin
				if (ln.scl_fall) begin
					sda_oe_o <= 1'b0;
					bit_cnt  <= '0;
					state    <= (rw == ISR_DIR_WRITE) ? ST_WRX : ST_RLOAD;
				end
			end
			ST_WACK: begin
				if (ln.scl_fall) begin
					sda_oe_o <= 1'b0;
					bit_cnt  <= '0;
					state    <= ST_WRX;
				end
			end
			ST_RLOAD: begin
				// data must arrive within the low phase; no clock stretching
				if (ln.scl_rise) begin
					state <= ST_IDLE;
				end else if (rbuf_valid) begin
					sh       <= rbuf;
					sda_oe_o <= ~rbuf[ISR_DATA_W-1];
					bit_cnt  <= '0;
					state    <= ST_RTX;
				end
			end
			ST_RTX: begin
				if (ln.scl_fall) begin
					if (bit_cnt == ISR_LAST_BIT) begin
						sda_oe_o <= 1'b0;             // release for master ack
						state    <= ST_RACK;
					end else begin
						bit_cnt  <= bit_cnt + 3'h1;
						sh       <= {sh[ISR_DATA_W-2:0], 1'b0};
						sda_oe_o <= ~sh[ISR_DATA_W-2];
					end
				end
			end
			ST_RACK: begin
				if (ln.scl_rise && ln.sda) begin
					state <= ST_IDLE;
				end else if (ln.scl_fall) begin
					state <= ST_RLOAD;
				end
			end
			default: begin
				state    <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end
			endcase
		end
	end

	// open drain: only ever pull low; the clock line has no driver at all
	always_ff @(posedge clk_link_i) begin
		sda_o <= 1'b0;
	end

	// ------------------------------------------------------------
	// register pointer
	// ------------------------------------------------------------
	// bus stop or start leaves the pointer alone so reads can follow
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			ptr <= ISR_PTR_RST;
		end else if (ptr_load) begin
			ptr <= {addr_hi, sh};
		end else if (data_wr || rd_fetch) begin
			ptr <= ptr + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// link side of the handshake
	// ------------------------------------------------------------
	logic                  op_pend;
	logic                  op_we;
	logic [ISR_ADDR_W-1:0] op_addr;
	logic [ISR_DATA_W-1:0] op_data;
	logic                  req_tgl;
	logic                  req_we;
	logic [ISR_ADDR_W-1:0] req_addr;
	logic [ISR_DATA_W-1:0] req_data;
	logic                  ack_tgl;
	logic                  ack_m;
	logic                  ack_s;
	logic                  ack_d;
	logic                  ack_evt;
	logic                  busy;
	logic                  issue;
	logic                  stale;
	logic [ISR_DATA_W-1:0] rd_hold;

	assign ack_evt = ack_s ^ ack_d;
	assign busy    = req_tgl ^ ack_s;
	// never issue in an ack cycle, so a new read cannot meet old data
	assign issue   = op_pend && !busy && !ack_evt;

	// one-deep queue of accesses; the serial rate keeps it from overrunning
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			op_pend <= 1'b0;
			op_we   <= 1'b0;
			op_addr <= '0;
			op_data <= '0;
		end else begin
			if (issue) begin
				op_pend <= 1'b0;
			end
			if (data_wr || rd_fetch) begin
				op_pend <= 1'b1;
				op_we   <= data_wr;
				op_addr <= ptr;
				op_data <= sh;
			end
		end
	end

	// payload is held steady until the acknowledge toggle returns
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			req_tgl  <= 1'b0;
			req_we   <= 1'b0;
			req_addr <= '0;
			req_data <= '0;
		end else if (issue) begin
			req_tgl  <= ~req_tgl;
			req_we   <= op_we;
			req_addr <= op_addr;
			req_data <= op_data;
		end
	end

	// acknowledge toggle synchroniser
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			ack_d <= 1'b0;
		end else begin
			ack_m <= ack_tgl;
			ack_s <= ack_m;
			ack_d <= ack_s;
		end
	end

	// a read still in flight when the transfer ends is answered but dropped
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			stale <= 1'b0;
		end else begin
			if (ack_evt) begin
				stale <= 1'b0;
			end
			if ((ln.start || ln.stop) && busy && !req_we) begin
				stale <= 1'b1;
			end
		end
	end

	// read data buffer; a returning answer wins over a clear
	always_ff @(posedge clk_link_i) begin
		if (!rst_link_n) begin
			rbuf       <= '0;
			rbuf_valid <= 1'b0;
		end else begin
			if (rbuf_take || ln.start || ln.stop || (issue && !op_we)) begin
				rbuf_valid <= 1'b0;
			end
			if (ack_evt && !req_we && !stale) begin
				rbuf       <= rd_hold;
				rbuf_valid <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// system side of the handshake
	// ------------------------------------------------------------
	logic req_m;
	logic req_s;
	logic req_d;
	logic req_evt;
	logic rd_cap;

	assign req_evt = req_s ^ req_d;

	// request toggle synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			req_d <= 1'b0;
		end else begin
			req_m <= req_tgl;
			req_s <= req_m;
			req_d <= req_s;
		end
	end

	// register strobes; payload is stable while the toggle is pending
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_wr_o    <= 1'b0;
			reg_rd_o    <= 1'b0;
			reg_addr_o  <= ISR_PTR_RST;
			reg_wdata_o <= '0;
			rd_cap      <= 1'b0;
		end else begin
			reg_wr_o <= req_evt && req_we;
			reg_rd_o <= req_evt && !req_we;
			rd_cap   <= reg_rd_o;
			if (req_evt) begin
				reg_addr_o  <= req_addr;
				reg_wdata_o <= req_data;
			end
		end
	end

	// answer: writes at once, reads once the register data has been caught
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ack_tgl <= 1'b0;
			rd_hold <= '0;
		end else if (rd_cap) begin
			rd_hold <= reg_rdata_i;
			ack_tgl <= ~ack_tgl;
		end else if (req_evt && req_we) begin
			ack_tgl <= ~ack_tgl;
		end
	end

endmodule

// ===== sim/isr_i2c_slave_properties.sv
/* checker: timing relations on the slave's pins and register strobes.
   assumes it is bound to every instance of the slave. */
`timescale 1ns/10ps
module isr_i2c_slave_properties
	import isr_pkg::*;
(
	input wire logic                  clk_sys_i,
	input wire logic                  rst_n_i,
	input wire logic                  clk_link_i,
	input wire logic                  scl_i,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_o,
	input wire logic [ISR_SEL_W-1:0]  addr_sel_i,
	input wire logic [ISR_ADDR_W-1:0] reg_addr_o,
	input wire logic [ISR_DATA_W-1:0] reg_wdata_o,
	input wire logic                  reg_wr_o,
	input wire logic                  reg_rd_o,
	input wire logic [ISR_DATA_W-1:0] reg_rdata_i
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// open drain: the pin may only ever be pulled low
	property p_drive_low;
		@(posedge clk_link_i) disable iff (!rst_n_i) sda_o == 1'h0;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("data drive not low");
	// strobes are single pulses, spaced apart, never together
	property p_wr_gap;
		@(posedge clk_sys_i) disable iff (!rst_n_i) reg_wr_o |=> (!reg_wr_o && !reg_rd_o) [*4];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("write strobe too close");
	property p_rd_gap;
		@(posedge clk_sys_i) disable iff (!rst_n_i) reg_rd_o |=> (!reg_rd_o && !reg_wr_o) [*4];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("read strobe too close");
	property p_one_access;
		@(posedge clk_sys_i) disable iff (!rst_n_i) !(reg_wr_o && reg_rd_o);
	endproperty
	a_one_access: assert property (p_one_access) else $error("read and write together");
	// address and data hold after an access so the far side may sample late
	property p_addr_held;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
			(reg_wr_o || reg_rd_o) |=> $stable(reg_addr_o) && $stable(reg_wdata_o);
	endproperty
	a_addr_held: assert property (p_addr_held) else $error("address not held");
	property p_rst_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
			$rose(rst_n_i) |-> (reg_addr_o == 16'h0000 && !reg_wr_o && !reg_rd_o);
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("pointer not cleared");
	// the slave only starts driving while the clock line is low
	property p_oe_rise_low;
		@(posedge clk_link_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> !scl_i;
	endproperty
	a_oe_rise_low: assert property (p_oe_rise_low) else $error("drive began, clock high");
	property p_oe_stands;
		@(posedge clk_link_i) disable iff (!rst_n_i) $rose(sda_oe_o) |=> sda_oe_o [*8];
	endproperty
	a_oe_stands: assert property (p_oe_stands) else $error("drive too short");
	property p_hold_high;
		@(posedge clk_link_i) disable iff (!rst_n_i)
			(sda_oe_o && $rose(scl_i)) |=> sda_oe_o [*8];
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("drive moved, clock high");
	c_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) reg_wr_o);
	c_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) reg_rd_o);
	c_drive: cover property (@(posedge clk_link_i) disable iff (!rst_n_i) $rose(sda_oe_o));
endmodule
bind isr_i2c_slave isr_i2c_slave_properties u_props (.clk_sys_i, .rst_n_i, .clk_link_i,
	.scl_i, .sda_i, .sda_o, .sda_oe_o, .addr_sel_i, .reg_addr_o, .reg_wdata_o,
	.reg_wr_o, .reg_rd_o, .reg_rdata_i);

// ===== sim/isr_bus_master.sv
/* partner: two-wire bus master owning the clock line and pulling data low.
   assumes the bench forms the pulled-up data line level from all drivers. */
`timescale 1ns/10ps
module isr_bus_master #(
	parameter int Q = 32
) (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_drv_o
);
	// ------------------------------------------------------------
	// bus actions
	// ------------------------------------------------------------
	// idle bus: clock high, data released
	initial begin
		scl_o = 1'h1;
		sda_drv_o = 1'h0;
	end
	// quarter bit; moves land just after a clock edge
	task automatic q_wait;
		repeat (Q) @(posedge clk_i);
		#1;
	endtask
	// data moves a quarter bit after the fall, well past the slave's hold need
	task automatic bit_x(input logic b, output logic seen);
		sda_drv_o = ~b;
		q_wait();
		scl_o = 1'h1;
		q_wait();
		seen = sda_i;
		q_wait();
		scl_o = 1'h0;
		q_wait();
	endtask
	// start or repeated start: data falls with the clock high
	task automatic start_c;
		sda_drv_o = 1'h0;
		q_wait();
		scl_o = 1'h1;
		q_wait();
		sda_drv_o = 1'h1;
		q_wait();
		scl_o = 1'h0;
		q_wait();
	endtask
	// stop: data low in the low phase, released in the high phase
	task automatic stop_c;
		sda_drv_o = 1'h1;
		q_wait();
		scl_o = 1'h1;
		q_wait();
		sda_drv_o = 1'h0;
		q_wait();
	endtask
	// byte out msb first, then the receiver's acknowledge slot
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'h1, ack);
	endtask
	// byte in; low acknowledges, high on the last byte ends the read
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'h1, d[i]);
		bit_x(last, s);
	endtask
endmodule

// ===== sim/testbench.sv
/* testbench: bus master model on the serial pins, byte memory on the strobes.
   assumes the slave keeps its default base address. */
`timescale 1ns/10ps
module testbench
	import isr_pkg::*;
;
	logic                  clk_sys_i   = 1'h0;
	logic                  clk_link    = 1'h0;
	logic                  rst_n       = 1'h0;
	logic [ISR_SEL_W-1:0]  sel         = 2'h0;
	logic [ISR_DATA_W-1:0] rdata       = 8'h00;
	logic [15:0]           last_wa     = 16'h0000;
	logic                  scl, drv, sda_oe, sda_out, wr, rd;
	logic [ISR_ADDR_W-1:0] addr;
	logic [ISR_DATA_W-1:0] wdata;
	logic [7:0]            mem [256];
	int                    wr_count    = 0;
	int                    bad_count   = 0;
	int                    checks_done = 0;
	wire                   sda_w;
	// ------------------------------------------------------------
	// clocks, wire, models
	// ------------------------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;
	always #7.5 clk_link = ~clk_link;
	// pulled-up line: low while either side pulls it
	assign sda_w = (sda_oe === 1'h1 || drv === 1'h1) ? 1'h0 : 1'h1;
	// read data valid only in the cycle after a read, churns otherwise
	always @(posedge clk_sys_i) begin
		if (wr === 1'h1) begin
			mem[addr[7:0]] <= wdata;
			wr_count <= wr_count + 1;
			last_wa <= addr;
		end
		rdata <= (rd === 1'h1) ? mem[addr[7:0]] : ~rdata;
	end
	isr_bus_master m (.clk_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_drv_o(drv));
	isr_i2c_slave DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .clk_link_i(clk_link),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe),
		.addr_sel_i(sel), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_rdata_i(rdata));
	// ------------------------------------------------------------
	// helpers and scenarios
	// ------------------------------------------------------------
	function automatic logic [7:0] ab(input logic dir);
		return {ISR_SLV_BASE_DEF[6:2], sel, dir};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// start, own address for writing, pointer high then low
	task automatic set_ptr(input logic [15:0] p);
		logic a;
		m.start_c();
		m.wr_byte(ab(ISR_DIR_WRITE), a);
		check("addr ack", a, 1'h0);
		m.wr_byte(p[15:8], a);
		check("hi ack", a, 1'h0);
		m.wr_byte(p[7:0], a);
		check("lo ack", a, 1'h0);
	endtask
	// two bytes across a carry of the low pointer byte
	task automatic t_write;
		logic a;
		int   n;
		n = wr_count;
		set_ptr(16'h12FF);
		m.wr_byte(8'hC3, a);
		check("data0 ack", a, 1'h0);
		m.wr_byte(8'h3C, a);
		check("data1 ack", a, 1'h0);
		m.stop_c();
		repeat (16) @(posedge clk_sys_i);
		check("writes", 16'(wr_count - n), 16'h0002);
		check("mem ff", mem[8'hFF], 8'hC3);
		check("mem 00", mem[8'h00], 8'h3C);
		check("last addr", last_wa, 16'h1300);
		$display("t_write done");
	endtask
	// pointer write, repeated start, two reads ended by nonacknowledge
	task automatic t_comb;
		logic       a;
		logic [7:0] d;
		set_ptr(16'h12FF);
		m.start_c();
		m.wr_byte(ab(1'h1), a);
		check("rd addr ack", a, 1'h0);
		m.rd_byte(1'h0, d);
		check("rd byte0", d, 8'hC3);
		m.rd_byte(1'h1, d);
		check("rd byte1", d, 8'h3C);
		m.stop_c();
		check("released", sda_oe, 1'h0);
		$display("t_comb done");
	endtask
	// other selected address; pointer-only write, then a separate read
	task automatic t_send;
		logic       a;
		logic [7:0] d;
		@(posedge clk_sys_i);
		#1 sel = 2'h3;
		set_ptr(16'h12FF);
		m.stop_c();
		m.start_c();
		m.wr_byte(ab(1'h1), a);
		check("sel ack", a, 1'h0);
		m.rd_byte(1'h1, d);
		check("kept ptr", d, 8'hC3);
		m.stop_c();
		$display("t_send done");
	endtask
	// foreign address: no acknowledge, no drive, no access
	task automatic t_miss;
		logic a;
		int   n;
		n = wr_count;
		m.start_c();
		m.wr_byte({ISR_SLV_BASE_DEF[6:2], 2'h0, ISR_DIR_WRITE}, a);
		check("miss ack", a, 1'h1);
		m.wr_byte(8'h00, a);
		check("miss byte", a, 1'h1);
		m.stop_c();
		check("miss writes", 16'(wr_count - n), 16'h0000);
		$display("t_miss done");
	endtask
	// partial bytes cut by a start and by a stop are dropped
	task automatic t_part;
		logic a;
		int   n;
		n = wr_count;
		set_ptr(16'h12FF);
		for (int i = 0; i < 4; i++)
			m.bit_x(1'h0, a);
		m.start_c();
		m.wr_byte(ab(ISR_DIR_WRITE), a);
		check("restart ack", a, 1'h0);
		for (int i = 0; i < 3; i++)
			m.bit_x(1'h0, a);
		m.stop_c();
		repeat (16) @(posedge clk_sys_i);
		check("part writes", 16'(wr_count - n), 16'h0000);
		check("part mem", mem[8'hFF], 8'hC3);
		$display("t_part done");
	endtask
	// main sequence; reset covers enough link edges for its synchroniser
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i);
		repeat (4) @(posedge clk_sys_i);
		#1 rst_n = 1'h1;
		repeat (20) @(posedge clk_sys_i);
		t_write();
		t_comb();
		t_send();
		t_miss();
		t_part();
		close_out();
	end
	// watchdog: the scenarios need well under half of this span
	initial begin
		#600000;
		bad_count++;
		close_out();
	end
endmodule
